// file: logic/vid_i2c_ctrl.sv
// Bus controller for the voltage-ID target, commanded over AHB-Lite.
// Assumes one target on the link and whole-word single transfers.
`include "vid_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module vid_i2c_ctrl #(
  parameter logic [6:0] TARGET_ADDR = 7'h3A,
  parameter int STD_QTR = `VID_STD_QTR,
  parameter int FAST_QTR = `VID_FAST_QTR
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  vid_i2c_if.host bus
);
  import vid_pkg::*;

  if (FAST_QTR < 4 || STD_QTR < FAST_QTR || STD_QTR > 255) begin : g_chk
    $error("vid_i2c_ctrl quarter-period counts out of range");
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  logic wr_ph_r;
  logic [7:0] wofs_r;
  logic [10:0] cmd_r;
  logic nack_r;
  logic [7:0] rdata_r;
  logic go;
  host_state_type st_r;
  logic [31:0] status;

  assign status = {16'h0000, rdata_r, 6'h00, nack_r, (st_r != H_IDLE)};
  // A command written while busy is dropped; software polls busy first
  assign go = wr_ph_r && (wofs_r == `HOST_CMD_OFS) && (st_r == H_IDLE);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ph_r <= 1'b0;
      wofs_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (hready)
    begin
      wr_ph_r <= hsel && htrans[1] && hwrite;
      wofs_r <= haddr[7:0];
      if (hsel && htrans[1] && !hwrite)
      begin
        if (haddr[7:0] == `HOST_STAT_OFS)
        begin
          hrdata <= status;
        end
        else if (haddr[7:0] == `HOST_CMD_OFS)
        begin
          hrdata <= {21'h000000, cmd_r};
        end
        else
        begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmd_r <= 11'h000;
    end
    else if (go)
    begin
      cmd_r <= hwdata[10:0];
    end
  end

  // ----------------------------------------------------------------
  // Link sequencer: four ticks per bit, SCL high in the middle two
  // ----------------------------------------------------------------
  logic [0:0] sda_lvl;
  logic [7:0] div_r;
  logic tick;
  logic [1:0] q_r;
  logic [1:0] idx_r;
  logic [3:0] bit_r;
  logic [8:0] tx_r;
  logic [8:0] rx_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic rd;
  logic [7:0] next_byte;
  logic [1:0] byte_idx;

  pin_sync #(.W(1)) u_sda (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(bus.sda),
    .lvl(sda_lvl),
    .rise(),
    .fall()
  );

  assign rd = cmd_r[`HOST_CMD_READ_BIT];
  assign tick = (st_r != H_IDLE) && (div_r == 8'h00);
  // After an ack the following byte is loaded; a START reloads the current one
  assign byte_idx = (st_r == H_START) ? idx_r : idx_r + 2'd1;

  always_comb
  begin
    case (byte_idx)
      2'd0: next_byte = {TARGET_ADDR, 1'b0};
      2'd1: next_byte = {7'h00, cmd_r[`HOST_CMD_REG_BIT]};
      2'd2: next_byte = rd ? {TARGET_ADDR, 1'b1} : cmd_r[7:0];
      default: next_byte = 8'hFF;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_r <= 8'h00;
    end
    else if (go || div_r == 8'h00)
    begin
      // Fast quarter is set by the minimum low time, not the rate
      div_r <= cmd_r[`HOST_CMD_FAST_BIT] ? 8'(FAST_QTR - 1) : 8'(STD_QTR - 1);
    end
    else
    begin
      div_r <= div_r - 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r <= H_IDLE;
      q_r <= 2'd0;
      idx_r <= 2'd0;
      bit_r <= 4'h0;
      tx_r <= 9'h1FF;
      rx_r <= 9'h000;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      nack_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else if (go)
    begin
      st_r <= H_START;
      q_r <= 2'd0;
      idx_r <= 2'd0;
      nack_r <= 1'b0;
    end
    else if (tick)
    begin
      q_r <= q_r + 2'd1;
      case (st_r)
        H_START:
        begin
          case (q_r)
            2'd0: sda_oe_r <= 1'b0;
            2'd1: scl_oe_r <= 1'b0;
            2'd2: sda_oe_r <= 1'b1;
            default:
            begin
              scl_oe_r <= 1'b1;
              st_r <= H_BIT;
              bit_r <= 4'h0;
              tx_r <= {next_byte, 1'b1};
            end
          endcase
        end
        H_BIT:
        begin
          case (q_r)
            2'd0: sda_oe_r <= !tx_r[8];
            2'd1: scl_oe_r <= 1'b0;
            2'd2: rx_r <= {rx_r[7:0], sda_lvl[0]};
            default:
            begin
              scl_oe_r <= 1'b1;
              tx_r <= {tx_r[7:0], 1'b1};
              bit_r <= bit_r + 4'h1;
              if (bit_r == 4'h8)
              begin
                if (idx_r == 2'd3)
                begin
                  rdata_r <= rx_r[8:1];
                  st_r <= H_STOP;
                end
                else if (rx_r[0])
                begin
                  // Software retries a write that drew no ack
                  nack_r <= 1'b1;
                  st_r <= H_STOP;
                end
                else if (idx_r == 2'd2 && !rd)
                begin
                  st_r <= H_STOP;
                end
                else
                begin
                  idx_r <= idx_r + 2'd1;
                  st_r <= (idx_r == 2'd1 && rd) ? H_START : H_BIT;
                  bit_r <= 4'h0;
                  tx_r <= {next_byte, 1'b1};
                end
              end
            end
          endcase
        end
        H_STOP:
        begin
          case (q_r)
            2'd0: sda_oe_r <= 1'b1;
            2'd1: scl_oe_r <= 1'b0;
            2'd2: sda_oe_r <= 1'b0;
            default: st_r <= H_IDLE;
          endcase
        end
        default:
        begin
        end
      endcase
    end
  end

  assign bus.host_scl_oe = scl_oe_r;
  assign bus.host_sda_oe = sda_oe_r;
endmodule : vid_i2c_ctrl
`default_nettype wire

// file: logic/vid_cfg.svh
// Constants of the regulator voltage-ID target and its bus controller.
// Assumes a single 25 MHz system clock; included by both link ends.
`ifndef VID_CFG_SVH
`define VID_CFG_SVH

// ----------------------------------------------------------------
// Target register map (register-address bytes, reset values and bit positions)
// ----------------------------------------------------------------
`define VID_REG_OUTPUT_VOLTAGE_CODE 8'h00
`define VID_REG_CTRL 8'h01
`define VID_OUTPUT_VOLTAGE_CODE_RST 8'h32
`define VID_CTRL_RST 8'h09
`define VID_PAR_BIT 7
`define VID_CTRL_INT_BIT 7
`define VID_CTRL_VCHG_BIT 4
`define VID_CTRL_PWM_BIT 3
`define VID_CTRL_LATCH_BIT 0

// ----------------------------------------------------------------
// Setpoint scale, microvolts
// ----------------------------------------------------------------
`define VID_SET_BASE_UV 900000
`define VID_SET_STEP_UV 9375

// ----------------------------------------------------------------
// Link timing
// ----------------------------------------------------------------
`define VID_HCLK_NS 40
`define VID_STD_PERIOD_NS 10000
`define VID_FAST_LOW_NS 1300
`define VID_STD_QTR ((`VID_STD_PERIOD_NS / 4 + `VID_HCLK_NS - 1) / `VID_HCLK_NS)
`define VID_FAST_QTR ((`VID_FAST_LOW_NS / 2 + `VID_HCLK_NS - 1) / `VID_HCLK_NS)
`define VID_RESP_SCL 27

// ----------------------------------------------------------------
// Controller registers on AHB-Lite
// ----------------------------------------------------------------
`define HOST_CMD_OFS 8'h00
`define HOST_STAT_OFS 8'h04
`define HOST_CMD_REG_BIT 8
`define HOST_CMD_READ_BIT 9
`define HOST_CMD_FAST_BIT 10
`define HOST_STAT_BUSY_BIT 0
`define HOST_STAT_NACK_BIT 1

`endif

// file: logic/vid_pkg.sv
// Types shared by the two ends of the voltage-ID link.
// Assumes nothing beyond a SystemVerilog compiler.
package vid_pkg;
  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_REG, D_WDATA, D_RDATA, D_IGNORE} dev_state_type;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_state_type;
endpackage : vid_pkg

// file: logic/vid_i2c_if.sv
// Two-wire link between controller and target, open-drain wired.
// Assumes pull-ups: a line is low while any enable is high.
`timescale 1ns/1ps
`default_nettype none
interface vid_i2c_if;
  logic host_scl_oe;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  assign scl = !host_scl_oe;
  assign sda = !(host_sda_oe | dev_sda_oe);
  modport host (output host_scl_oe, output host_sda_oe, input scl, input sda);
  modport dev (output dev_sda_oe, input scl, input sda);
endinterface : vid_i2c_if
`default_nettype wire

// file: logic/pin_sync.sv
// Two-flop synchroniser with edge detection for pins.
// Assumes idle-high pins; edges are taken after the second flop.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] last_r;

  if (W < 1) begin : g_chk
    $error("pin_sync needs at least one pin");
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_r <= '1;
      sync_r <= '1;
      last_r <= '1;
    end
    else
    begin
      meta_r <= pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign lvl = sync_r;
  assign rise = sync_r & ~last_r;
  assign fall = ~sync_r & last_r;
endmodule : pin_sync
`default_nettype wire

// file: logic/vid_i2c_target.sv
// Regulator voltage-ID target: two-wire slave plus two-register bank.
// Assumes hclk is at least ten times faster than the link clock.
`include "vid_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module vid_i2c_target #(
  parameter logic [6:0] OWN_ADDR = 7'h3A
) (
  input wire logic hclk,
  input wire logic hresetn,
  vid_i2c_if.dev bus,
  input wire logic [6:0] ext_voltage_id,
  output logic [6:0] output_voltage_code,
  output logic [6:0] applied_voltage_id,
  output logic [20:0] setpoint_uv,
  output logic internal_mode,
  output logic protection_enable,
  output logic light_load_pwm_select,
  output logic latch_off_mode
);
  import vid_pkg::*;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  logic [1:0] lvl;
  logic [1:0] rise;
  logic [1:0] fall;
  logic scl_hi;
  logic scl_rise;
  logic scl_fall;
  logic sda_in;
  logic start_det;
  logic stop_det;

  pin_sync #(.W(2)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin({bus.scl, bus.sda}),
    .lvl(lvl),
    .rise(rise),
    .fall(fall)
  );

  assign scl_hi = lvl[1];
  assign scl_rise = rise[1];
  assign scl_fall = fall[1];
  assign sda_in = lvl[0];
  // Both lines pass the same delay, so their order is kept
  assign start_det = scl_hi && fall[0];
  assign stop_det = scl_hi && rise[0];

  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  dev_state_type state_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic ackph_r;
  logic sda_oe_r;
  logic reg_sel_r;
  logic [7:0] output_voltage_code_r;
  logic [7:0] ctrl_r;
  logic byte_end;
  logic addr_hit;
  logic par_ok;
  logic wr_go;

  assign byte_end = scl_fall && !ackph_r && (cnt_r == 4'h8);
  assign addr_hit = (sh_r[7:1] == OWN_ADDR);
  assign par_ok = (sh_r[`VID_PAR_BIT] == ~^sh_r[6:0]);
  assign wr_go = byte_end && (state_r == D_WDATA) && par_ok;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= D_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ackph_r <= 1'b0;
      sda_oe_r <= 1'b0;
      reg_sel_r <= 1'b0;
    end
    else if (start_det)
    begin
      // A START, repeated or not, always restarts address matching
      state_r <= D_ADDR;
      cnt_r <= 4'h0;
      ackph_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (stop_det)
    begin
      state_r <= D_IDLE;
      ackph_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      // Ninth pulse of an ack is not counted as a data bit
      if (scl_rise && !ackph_r && (state_r != D_IDLE))
      begin
        cnt_r <= cnt_r + 4'h1;
        sh_r <= {sh_r[6:0], sda_in};
      end
      if (scl_fall && ackph_r)
      begin
        // Ack ends: release, or put out the first read bit at once
        ackph_r <= 1'b0;
        cnt_r <= 4'h0;
        sda_oe_r <= (state_r == D_RDATA) && !tx_r[7];
      end
      else if (byte_end)
      begin
        cnt_r <= 4'h0;
        case (state_r)
          D_ADDR:
          begin
            if (addr_hit)
            begin
              sda_oe_r <= 1'b1;
              ackph_r <= 1'b1;
              state_r <= sh_r[0] ? D_RDATA : D_REG;
              tx_r <= reg_sel_r ? ctrl_r : output_voltage_code_r;
            end
            else
            begin
              state_r <= D_IGNORE;
            end
          end
          D_REG:
          begin
            // Only register addresses 0 and 1 exist; others are refused
            if (sh_r[7:1] == 7'h00)
            begin
              reg_sel_r <= sh_r[0];
              sda_oe_r <= 1'b1;
              ackph_r <= 1'b1;
              state_r <= D_WDATA;
            end
            else
            begin
              state_r <= D_IGNORE;
            end
          end
          D_WDATA:
          begin
            sda_oe_r <= par_ok;
            ackph_r <= par_ok;
            state_r <= D_IGNORE;
          end
          D_RDATA:
          begin
            // Controller's ack or nack after the byte does not matter
            sda_oe_r <= 1'b0;
            state_r <= D_IGNORE;
          end
          default:
          begin
          end
        endcase
      end
      else if (scl_fall && (state_r == D_RDATA))
      begin
        sda_oe_r <= !tx_r[6];
        tx_r <= {tx_r[6:0], 1'b1};
      end
    end
  end

  assign bus.dev_sda_oe = sda_oe_r;

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  // Loaded on the falling edge that opens the ack, well inside the
  // response time; a rejected byte leaves both registers untouched.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      output_voltage_code_r <= `VID_OUTPUT_VOLTAGE_CODE_RST;
      ctrl_r <= `VID_CTRL_RST;
    end
    else if (wr_go)
    begin
      if (reg_sel_r)
      begin
        ctrl_r <= sh_r;
      end
      else
      begin
        output_voltage_code_r <= sh_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // External code input
  // ----------------------------------------------------------------
  logic [6:0] ext_meta_r;
  logic [6:0] ext_sync_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_meta_r <= 7'h00;
      ext_sync_r <= 7'h00;
    end
    else
    begin
      ext_meta_r <= ext_voltage_id;
      ext_sync_r <= ext_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the regulator core
  // ----------------------------------------------------------------
  logic [6:0] applied_nxt;
  logic [20:0] setpoint_nxt;

  assign applied_nxt = ctrl_r[`VID_CTRL_INT_BIT] ? output_voltage_code_r[6:0] : ext_sync_r;
  assign setpoint_nxt = 21'(`VID_SET_BASE_UV) + 21'(applied_nxt) * 21'(`VID_SET_STEP_UV);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      output_voltage_code <= 7'h00;
      applied_voltage_id <= 7'h00;
      setpoint_uv <= 21'(`VID_SET_BASE_UV);
      internal_mode <= 1'b0;
      protection_enable <= 1'b1;
      light_load_pwm_select <= 1'b1;
      latch_off_mode <= 1'b1;
    end
    else
    begin
      output_voltage_code <= output_voltage_code_r[6:0];
      applied_voltage_id <= applied_nxt;
      setpoint_uv <= setpoint_nxt;
      internal_mode <= ctrl_r[`VID_CTRL_INT_BIT];
      // Dropped only for the cycle in which the applied code moves
      protection_enable <= !(ctrl_r[`VID_CTRL_VCHG_BIT] && (applied_nxt != applied_voltage_id));
      light_load_pwm_select <= ctrl_r[`VID_CTRL_PWM_BIT];
      latch_off_mode <= ctrl_r[`VID_CTRL_LATCH_BIT];
    end
  end
endmodule : vid_i2c_target
`default_nettype wire

// file: test/vid_link_props.sv
// Link checker: watches the two-wire bus between controller and target.
// Assumes hclk samples the wired lines directly; one target on the bus.
`timescale 1ns/1ps
`default_nettype none
module vid_link_props #(
  parameter logic [6:0] OWN_ADDR = 7'h3A,
  parameter int MIN_Q = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_r, sda_r, miss_r, rd_r, fall, start;
  logic [5:0] bcnt_r;
  logic [31:0] sh_r;
  logic [7:0] hi_r;
  assign fall = scl_r && !scl;
  assign start = scl && scl_r && sda_r && !sda;
  // ------------------------------------------------------------
  // Bit position since START; bit k is high while the count is k
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      bcnt_r <= 6'h00;
      sh_r <= 32'h0;
      hi_r <= 8'h00;
    end
    else
    begin
      scl_r <= scl;
      sda_r <= sda;
      sh_r <= (scl && !scl_r) ? {sh_r[30:0], sda} : sh_r;
      hi_r <= !scl ? 8'h00 : ((hi_r == 8'hFF) ? hi_r : hi_r + 8'h01);
      bcnt_r <= start ? 6'h00 : ((fall && bcnt_r != 6'h3F) ? bcnt_r + 6'h01 : bcnt_r);
    end
  end
  // Flags per transfer, cleared by every START
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      miss_r <= 1'b0;
      rd_r <= 1'b0;
    end
    else if (start)
    begin
      miss_r <= 1'b0;
      rd_r <= 1'b0;
    end
    else if (fall && bcnt_r == 6'h09)
    begin
      miss_r <= sh_r[8:2] != OWN_ADDR;
      rd_r <= sh_r[1] && sh_r[8:2] == OWN_ADDR;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_addr_end;
    fall && bcnt_r == 6'h09;
  endsequence
  sequence s_wdata_end;
    fall && bcnt_r == 6'h1B && sh_r[26:20] == OWN_ADDR && !sh_r[19] && sh_r[17:10] <= 8'h01;
  endsequence
  chk_addr_ack: assert property (s_addr_end ##0 sh_r[8:2] == OWN_ADDR |-> !sh_r[0])
    else $error("matching address not acknowledged");
  chk_addr_nack: assert property (s_addr_end ##0 sh_r[8:2] != OWN_ADDR |-> sh_r[0])
    else $error("foreign address acknowledged");
  chk_miss_quiet: assert property (miss_r |-> !dev_sda_oe)
    else $error("target drove data after foreign address");
  chk_only_ack: assert property (scl && !rd_r && bcnt_r % 9 != 0 |-> !dev_sda_oe)
    else $error("target drove data outside an ack slot");
  chk_read_release: assert property (scl && rd_r && bcnt_r == 6'h12 |-> !dev_sda_oe)
    else $error("target held data past the eighth read bit");
  chk_parity_nack: assert property (s_wdata_end ##0 sh_r[8] != ~^sh_r[7:1] |-> sh_r[0])
    else $error("bad parity byte acknowledged");
  chk_data_ack: assert property (s_wdata_end ##0 sh_r[8] == ~^sh_r[7:1] |-> !sh_r[0])
    else $error("valid data byte not acknowledged");
  chk_dev_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("target moved data while clock high");
  chk_scl_high_min: assert property (fall |-> hi_r >= 8'(2 * MIN_Q - 1))
    else $error("clock high phase too short");
  chk_host_release: assert property (scl && bcnt_r == 6'h09 |-> !host_sda_oe && !host_scl_oe)
    else $error("controller held data during address ack");
endmodule : vid_link_props
`default_nettype wire

// file: test/vid_i2c_target_regs_tb_top.sv
// Bench: controller and target joined by the link, driven over AHB-Lite.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module vid_i2c_target_regs_tb_top;
  import vid_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hsel2 = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic watch_far = 1'b0;
  logic resp1, resp2;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [6:0] ext_id = 7'h00;
  logic [31:0] hrdata1, hrdata2;
  logic rdy1, rdy2, intm, prot, pwm, latch;
  int dips = 0;
  logic [6:0] code, app, code2;
  logic [20:0] setp;
  int error_cnt = 0;
  int checked = 0;
  vid_i2c_if i_link ();
  vid_i2c_if i_link_far ();
  always #20 hclk = ~hclk;
  // Counts protection dip cycles; one code change must give exactly one
  always @(posedge hclk)
    if (prot === 1'b0)
      dips <= dips + 1;
  vid_i2c_ctrl #(.STD_QTR(8), .FAST_QTR(4)) i_vid_i2c_ctrl (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(rdy1), .hrdata(hrdata1), .hreadyout(rdy1),
    .hresp(resp1), .bus(i_link.host));
  // Far pair uses a foreign address to exercise the mismatch path
  vid_i2c_ctrl #(.TARGET_ADDR(7'h2A), .STD_QTR(8), .FAST_QTR(4)) i_vid_i2c_ctrl_far (.hclk,
    .hresetn, .hsel(hsel2), .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(rdy2),
    .hrdata(hrdata2), .hreadyout(rdy2), .hresp(resp2), .bus(i_link_far.host));
  vid_i2c_target i_vid_i2c_target (.hclk, .hresetn, .bus(i_link.dev), .ext_voltage_id(ext_id),
    .output_voltage_code(code), .applied_voltage_id(app), .setpoint_uv(setp),
    .internal_mode(intm), .protection_enable(prot), .light_load_pwm_select(pwm),
    .latch_off_mode(latch));
  vid_i2c_target i_vid_i2c_target_far (.hclk, .hresetn, .bus(i_link_far.dev),
    .ext_voltage_id(ext_id), .output_voltage_code(code2), .applied_voltage_id(),
    .setpoint_uv(), .internal_mode(), .protection_enable(), .light_load_pwm_select(),
    .latch_off_mode());
  // Checker follows the near link, or the far one for the foreign-address test
  vid_link_props i_vid_link_props (.hclk, .hresetn,
    .host_scl_oe(watch_far ? i_link_far.host_scl_oe : i_link.host_scl_oe),
    .host_sda_oe(watch_far ? i_link_far.host_sda_oe : i_link.host_sda_oe),
    .dev_sda_oe(watch_far ? i_link_far.dev_sda_oe : i_link.dev_sda_oe),
    .scl(watch_far ? i_link_far.scl : i_link.scl),
    .sda(watch_far ? i_link_far.sda : i_link.sda));
  // ------------------------------------------------------------
  // Expectations and bus tasks
  // ------------------------------------------------------------
  function automatic logic [7:0] vbyte(input logic [6:0] c);
    return {~^c, c};
  endfunction : vbyte
  function automatic logic [20:0] spt(input logic [6:0] c);
    return 21'hDBBA0 + 21'(c) * 21'h249F;
  endfunction : spt
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic ahb(input bit b, input bit wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= !b;
    hsel2 <= b;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do @(posedge hclk); while ((b ? rdy2 : rdy1) !== 1'b1);
    hsel <= 1'b0;
    hsel2 <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while ((b ? rdy2 : rdy1) !== 1'b1);
    q = b ? hrdata2 : hrdata1;
    chk("hresp", b ? resp2 : resp1, 32'h0);
  endtask : ahb
  // Issues one link command and polls until the controller is idle
  task automatic xfer(input bit b, input logic [10:0] c, output logic [31:0] st);
    int n;
    n = 0;
    ahb(b, 1'b1, 32'h0, {21'h0, c}, st);
    do
    begin
      ahb(b, 1'b0, 32'h4, 32'h0, st);
      n++;
    end
    while (st[0] !== 1'b0 && n < 4000);
    chk("idle", st[0], 32'h0);
  endtask : xfer
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  initial
  begin
    // About 25k cycles of traffic are expected; allow twice that
    #2000000;
    error_cnt++;
    end_sim();
  end
  initial
  begin
    logic [31:0] st;
    logic [6:0] c;
    int d0;
    void'($urandom(99));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("code", code, 32'h32);
    chk("internal", intm, 32'h0);
    chk("protect", prot, 32'h1);
    chk("pwm", pwm, 32'h1);
    chk("latch", latch, 32'h1);
    xfer(1'b0, 11'h200, st);
    chk("output_voltage_code read", st[15:8], 32'h32);
    xfer(1'b0, 11'h300, st);
    chk("ctrl read", st[15:8], 32'h09);
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      c = (i == 0) ? 7'h00 : ((i == 1) ? 7'h7F : 7'($urandom));
      xfer(1'b0, {1'($urandom), 2'h0, vbyte(c)}, st);
      chk("write nack", st[1], 32'h0);
      chk("code", code, c);
      xfer(1'b0, {1'($urandom), 2'h2, 8'h00}, st);
      chk("output_voltage_code read", st[15:8], vbyte(c));
    end
    xfer(1'b0, {3'h0, vbyte(c + 7'h01) ^ 8'h80}, st);
    chk("parity nack", st[1], 32'h1);
    chk("code kept", code, c);
    xfer(1'b0, {3'h0, vbyte(c + 7'h01)}, st);
    c = c + 7'h01;
    chk("retry nack", st[1], 32'h0);
    chk("code", code, c);
    xfer(1'b0, 11'h200, st);
    chk("output_voltage_code reread", st[15:8], vbyte(c));
    $display("test voltage writes done");
    ext_id <= 7'($urandom);
    xfer(1'b0, 11'h198, st);
    chk("internal", intm, 32'h1);
    chk("latch", latch, 32'h0);
    chk("applied", app, c);
    chk("setpoint", setp, spt(c));
    d0 = dips;
    xfer(1'b0, {3'h0, vbyte(c ^ 7'h05)}, st);
    chk("dip", dips - d0, 32'h1);
    xfer(1'b0, 11'h189, st);
    xfer(1'b0, 11'h188, st);
    chk("ctrl nack", st[1], 32'h1);
    d0 = dips;
    xfer(1'b0, {3'h0, vbyte(c)}, st);
    chk("no dip", dips - d0, 32'h0);
    chk("latch", latch, 32'h1);
    ahb(1'b0, 1'b0, 32'h0, 32'h0, st);
    chk("cmd readback", st[10:0], {3'h0, vbyte(c)});
    ahb(1'b0, 1'b0, 32'h8, 32'h0, st);
    chk("unmapped", st, 32'h0);
    xfer(1'b0, 11'h101, st);
    repeat (8) @(posedge hclk);
    chk("internal", intm, 32'h0);
    chk("pwm", pwm, 32'h0);
    chk("applied", app, ext_id);
    chk("setpoint", setp, spt(ext_id));
    $display("test control done");
    watch_far <= 1'b1;
    xfer(1'b1, {3'h0, vbyte(7'h15)}, st);
    chk("foreign nack", st[1], 32'h1);
    chk("foreign code", code2, 32'h32);
    $display("test address mismatch done");
    end_sim();
  end
endmodule : vid_i2c_target_regs_tb_top
`default_nettype wire
